// *** sar_afe_model.sv ***
// analog front end model: comparator against the held input level
module sar_afe_model (
    // trial code from the converter and level under test
    input wire logic [11:0] trial_code_in,
    input wire logic [11:0] level_in,
    // decision back to the converter
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // straight binary, one code step per reference over 4096
    assign comparator_out = (level_in >= trial_code_in);
endmodule

// *** sar_pkg.sv ***
// types for the serial readout converter control
package sar_pkg;
    typedef enum logic [2:0] {
        SAR_IDLE,
        SAR_SAMPLE,
        SAR_CONVERT,
        SAR_REPEAT,
        SAR_DONE
    } sar_state_t;
endpackage

// *** sar_readout.sv ***
// conversion sequencing and serial result output of a 12-bit sar converter
// Behaviour
// - output bits launch on conversion clock falls
// - select falling starts conversion and transfer
// - sample 1.5 to 2 clocks first
// - enable output after second fall, null low
// - next 12 clocks give result, msb first
// - further clocks repeat result lsb first
// - after top bit repeat, tri-state, ignore clocks
// - restart only after select high then low
// - capture difference once at hold entry
// - straight unsigned binary result code
// - one code step is reference over 4096
// - select low active, high means shutdown
// - select high aborts conversion any time
// - analog off at completion, digital off deselected
`include "sar_regs.svh"
module sar_readout (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // serial link pins
    input wire logic select_shutdown_n_in,
    input wire logic conversion_clock_in,
    output logic dout_out,
    output logic dout_oe_out,
    // analog front end control
    input wire logic comparator_in,
    output logic sample_out,
    output logic [`SAR_RES_W-1:0] trial_code_out,
    output logic analog_power_out,
    output logic digital_power_out,
    // parallel result stream
    output logic [`SAR_RES_W-1:0] result_data_out,
    output logic result_valid_out,
    input wire logic result_ready_in
);
    sar_pkg::sar_state_t state_q, state_d;
    logic sel_prev_q, sel_prev_d;
    logic clk_prev_q, clk_prev_d;
    logic [1:0] edge_cnt_q, edge_cnt_d;
    logic [`SAR_IDX_W-1:0] idx_q, idx_d;
    logic [`SAR_RES_W-1:0] trial_q, trial_d;
    logic dout_q, dout_d, oe_q, oe_d;
    logic sample_q, sample_d, apwr_q, apwr_d, dpwr_q, dpwr_d;
    // finished word, held apart from the trial register, and its pending push
    logic push_q, push_d, word_done;
    logic [`SAR_RES_W-1:0] word_q, word_d;
    logic buf_ready;
    logic sel_fall, clk_fall;

    // pins are synchronous to mclk, one flop of history finds the edges
    assign sel_fall = sel_prev_q & ~select_shutdown_n_in;
    assign clk_fall = clk_prev_q & ~conversion_clock_in;

    // pin history: one flop per pin, reset to 0 so that a select already
    // low when reset ends is never taken for a fall
    always_comb begin
        sel_prev_d = select_shutdown_n_in;
        clk_prev_d = conversion_clock_in;
    end

    // pin history registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sel_prev_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_prev_d;
            clk_prev_q <= clk_prev_d;
        end
    end

    // sequencer next values
    always_comb begin
        state_d = state_q;
        edge_cnt_d = edge_cnt_q;
        idx_d = idx_q;
        trial_d = trial_q;
        dout_d = dout_q;
        oe_d = oe_q;
        sample_d = sample_q;
        apwr_d = apwr_q;
        dpwr_d = ~select_shutdown_n_in;
        // flags the cycle whose fall decides the last result bit
        word_done = 1'b0;
        if (select_shutdown_n_in) begin
            // deselected: abort whatever runs, full shutdown
            state_d = sar_pkg::SAR_IDLE;
            oe_d = 1'b0;
            dout_d = 1'b0;
            sample_d = 1'b0;
            apwr_d = 1'b0;
        end else if (state_q == sar_pkg::SAR_IDLE) begin
            // only a real fall starts, a held low never restarts
            if (sel_fall) begin
                state_d = sar_pkg::SAR_SAMPLE;
                edge_cnt_d = 2'd0;
                sample_d = 1'b1;
                apwr_d = 1'b1;
                trial_d = `SAR_ZERO_CODE;
            end
        end else if (clk_fall) begin
            case (state_q)
                sar_pkg::SAR_SAMPLE: begin
                    edge_cnt_d = edge_cnt_q + 2'd1;
                    if (edge_cnt_q == `SAR_HOLD_EDGE) begin
                        // second fall: hold the difference once, drive null
                        state_d = sar_pkg::SAR_CONVERT;
                        sample_d = 1'b0;
                        oe_d = 1'b1;
                        dout_d = 1'b0;
                        trial_d = `SAR_MID_CODE;
                        idx_d = `SAR_TOP_IDX;
                    end
                end
                sar_pkg::SAR_CONVERT: begin
                    // comparator high keeps the trial bit: straight binary
                    trial_d[idx_q] = comparator_in;
                    dout_d = comparator_in;
                    if (idx_q == 4'd0) begin
                        // last decision: analog off, word handed on
                        state_d = sar_pkg::SAR_REPEAT;
                        idx_d = 4'd1;
                        apwr_d = 1'b0;
                        word_done = 1'b1;
                    end else begin
                        trial_d[idx_q - 4'd1] = 1'b1;
                        idx_d = idx_q - 4'd1;
                    end
                end
                sar_pkg::SAR_REPEAT: begin
                    if (idx_q == `SAR_END_IDX) begin
                        state_d = sar_pkg::SAR_DONE;
                        oe_d = 1'b0;
                        dout_d = 1'b0;
                    end else begin
                        dout_d = trial_q[idx_q];
                        idx_d = idx_q + 4'd1;
                    end
                end
                default: begin
                    // done: clock edges have no effect until deselect,
                    // so a select held low never starts a second word
                    state_d = state_q;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_q <= sar_pkg::SAR_IDLE;
            edge_cnt_q <= 2'd0;
            idx_q <= 4'd0;
            trial_q <= `SAR_ZERO_CODE;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            sample_q <= 1'b0;
            apwr_q <= 1'b0;
            dpwr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            edge_cnt_q <= edge_cnt_d;
            idx_q <= idx_d;
            trial_q <= trial_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            sample_q <= sample_d;
            apwr_q <= apwr_d;
            dpwr_q <= dpwr_d;
        end
    end

    // finished word is copied out of the trial register: the next select
    // fall clears that register while an older word may still wait here
    always_comb begin
        word_d = word_q;
        // pending word waits for buffer room; a new word wins over the drain
        push_d = push_q & ~buf_ready;
        if (word_done) begin
            word_d = trial_d;
            push_d = 1'b1;
        end
    end

    // result hold registers; with the buffer full and this word waiting,
    // a fourth finished word overwrites it if the reader never drains
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            word_q <= `SAR_ZERO_CODE;
            push_q <= 1'b0;
        end else begin
            word_q <= word_d;
            push_q <= push_d;
        end
    end

    // finished words queue here so a stalled reader loses none
    // as long as it drains before a fourth word finishes behind the buffer
    sar_skid u_buf (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(push_q),
        .in_data_in(word_q),
        .in_ready_out(buf_ready),
        .out_valid_out(result_valid_out),
        .out_data_out(result_data_out),
        .out_ready_in(result_ready_in)
    );

    // pin and control outputs straight from flops
    // dout is held low whenever oe is low, so a released pin reads 0
    assign dout_out = dout_q;
    assign dout_oe_out = oe_q;
    assign sample_out = sample_q;
    assign trial_code_out = trial_q;
    assign analog_power_out = apwr_q;
    assign digital_power_out = dpwr_q;
endmodule

// *** sar_readout_chk.sv ***
// assertion checker for the serial readout converter control
`include "sar_regs.svh"
module sar_readout_chk (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic select_shutdown_n_in,
    input wire logic conversion_clock_in,
    input wire logic dout_out,
    input wire logic dout_oe_out,
    input wire logic sample_out,
    input wire logic analog_power_out,
    input wire logic digital_power_out,
    input wire logic [`SAR_RES_W-1:0] result_data_out,
    input wire logic result_valid_out,
    input wire logic result_ready_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    logic clk_q;
    logic fell_q;
    // fall seen one edge ago, as the design reacts to it
    always_ff @(posedge mclk_in) begin
        clk_q <= conversion_clock_in;
        fell_q <= clk_q & ~conversion_clock_in;
    end
    a_abort_quiet: assert property (select_shutdown_n_in |=>
        !dout_oe_out && !sample_out && !analog_power_out) else $error("abort ignored");
    a_digital_follow: assert property (1'b1 |=>
        digital_power_out == !$past(select_shutdown_n_in)) else $error("digital power");
    a_pins_stand: assert property (!$fell(conversion_clock_in) &&
        !select_shutdown_n_in |=> $stable({dout_out, dout_oe_out})) else $error("pin moved");
    a_null_first: assert property ($rose(dout_oe_out) |->
        !dout_out && fell_q && !sample_out) else $error("null bit");
    a_hold_on_fall: assert property ($fell(sample_out) |->
        fell_q || $past(select_shutdown_n_in) || $past(rst_in)) else $error("hold entry");
    a_sample_start: assert property ($rose(sample_out) |->
        !$past(select_shutdown_n_in) && $past(select_shutdown_n_in, 2)) else $error("start");
    a_analog_off: assert property ($fell(analog_power_out) |->
        fell_q || $past(select_shutdown_n_in) || $past(rst_in)) else $error("analog off");
    a_word_stands: assert property (result_valid_out && !result_ready_in |=>
        result_valid_out && $stable(result_data_out)) else $error("word dropped");
endmodule
bind sar_readout sar_readout_chk i_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .select_shutdown_n_in(select_shutdown_n_in), .conversion_clock_in(conversion_clock_in),
    .dout_out(dout_out), .dout_oe_out(dout_oe_out), .sample_out(sample_out),
    .analog_power_out(analog_power_out), .digital_power_out(digital_power_out),
    .result_data_out(result_data_out), .result_valid_out(result_valid_out),
    .result_ready_in(result_ready_in));

// *** sar_readout_tb.sv ***
// self-checking bench for the serial readout converter control
module sar_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sel_n = 1'b1;
    logic dclk = 1'b0;
    logic ready = 1'b0;
    logic [11:0] vin = 12'h000;
    logic comp, dout, oe, smp, apw, dpw, valid;
    logic [11:0] trial, rdata;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    // 100 mhz system clock
    always #5 mclk_in = ~mclk_in;
    sar_readout i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .select_shutdown_n_in(sel_n),
        .conversion_clock_in(dclk), .dout_out(dout), .dout_oe_out(oe), .comparator_in(comp),
        .sample_out(smp), .trial_code_out(trial), .analog_power_out(apw),
        .digital_power_out(dpw), .result_data_out(rdata), .result_valid_out(valid),
        .result_ready_in(ready));
    sar_afe_model i_afe (.trial_code_in(trial), .level_in(vin), .comparator_out(comp));
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // one framed conversion with nf host clock falls, pins checked after each
    task automatic conv(input logic [11:0] code, input int nf);
        logic e_oe, e_d, e_s, e_a;
        logic [11:0] sh;
        sh = 12'h000;
        vin <= code;
        sel_n <= 1'b1;
        tick(2);
        sel_n <= 1'b0;
        tick(3);
        chk(smp, 1'b1, "not sampling");
        chk(dpw, 1'b1, "digital off");
        for (int k = 1; k <= nf; k++) begin
            dclk <= 1'b1;
            tick(2);
            dclk <= 1'b0;
            tick(3);
            e_oe = (k >= 2 && k <= 25);
            e_d = (k <= 2) ? 1'b0 : (k <= 14) ? code[14-k] : code[k-14];
            e_s = (k < 2);
            e_a = (k < 14);
            chk(oe, e_oe, "enable");
            if (e_oe) chk(dout, e_d, "serial bit");
            chk(smp, e_s, "sample");
            chk(apw, e_a, "analog power");
            // host side: bit taken before the next rise, sampling and null skipped
            if (k >= 3 && k <= 14) sh = {sh[10:0], dout};
        end
        if (nf >= 14) chk(sh, code, "serial word");
    endtask
    // pop one word; ready high for exactly one edge
    task automatic take(input logic [11:0] code);
        chk(valid, 1'b1, "no word");
        chk(rdata, code, "word value");
        ready <= 1'b1;
        tick(1);
        ready <= 1'b0;
        tick(3);
    endtask
    task automatic t_stream;
        conv(12'h800, 28);
        conv(12'hfff, 26);
        take(12'h800);
        take(12'hfff);
        conv(12'h000, 30);
        take(12'h000);
        chk(valid, 1'b0, "buffer not empty");
        $display("test stream done");
    endtask
    task automatic t_abort;
        conv(12'ha5c, 8);
        sel_n <= 1'b1;
        tick(3);
        chk(oe, 1'b0, "still driven");
        chk(dpw, 1'b0, "digital on");
        chk(valid, 1'b0, "short word pushed");
        $display("test abort done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far above the at most 155 cycles per conversion
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        tick(8);
        rst_in <= 1'b0;
        tick(2);
        t_stream();
        t_abort();
        close_out();
    end
endmodule

// *** sar_regs.svh ***
// constants for the serial readout converter control
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH
`define SAR_RES_W 12
`define SAR_IDX_W 4
`define SAR_HOLD_EDGE 2'd1
`define SAR_TOP_IDX 4'd11
`define SAR_END_IDX 4'd12
`define SAR_MID_CODE 12'h800
`define SAR_ZERO_CODE 12'h000
`endif

// *** sar_skid.sv ***
// two-entry result buffer with valid and ready on both sides
`include "sar_regs.svh"
module sar_skid (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // filling side
    input wire logic in_valid_in,
    input wire logic [`SAR_RES_W-1:0] in_data_in,
    output logic in_ready_out,
    // draining side
    output logic out_valid_out,
    output logic [`SAR_RES_W-1:0] out_data_out,
    input wire logic out_ready_in
);
    logic head_v_q, head_v_d, tail_v_q, tail_v_d;
    logic [`SAR_RES_W-1:0] head_q, head_d, tail_q, tail_d;
    logic push, pop;

    // tail only fills while head is held, so order is kept
    always_comb begin
        push = in_valid_in & ~tail_v_q;
        pop = head_v_q & out_ready_in;
        head_v_d = head_v_q;
        head_d = head_q;
        tail_v_d = tail_v_q;
        tail_d = tail_q;
        if (pop) begin
            head_v_d = tail_v_q;
            head_d = tail_q;
            tail_v_d = 1'b0;
        end
        if (push) begin
            if (!head_v_d) begin
                head_v_d = 1'b1;
                head_d = in_data_in;
            end else begin
                tail_v_d = 1'b1;
                tail_d = in_data_in;
            end
        end
    end

    // storage registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
            head_q <= `SAR_ZERO_CODE;
            tail_q <= `SAR_ZERO_CODE;
        end else begin
            head_v_q <= head_v_d;
            tail_v_q <= tail_v_d;
            head_q <= head_d;
            tail_q <= tail_d;
        end
    end

    // ready is full-flag based, so it stays a flop output
    assign in_ready_out = ~tail_v_q;
    assign out_valid_out = head_v_q;
    assign out_data_out = head_q;
endmodule
